// ---- rtl/dsk_sync_pkg.sv ----
//==============================================================
package dsk_sync_pkg;

  //==============================================================
  // timing
  localparam int        CLK_MHZ      = 100;
  localparam int        SLOT_NS_FM   = 2000;  // half of a 4 us cell
  localparam int        SLOT_NS_MFM  = 1000;
  localparam int        PULSE_NS     = 250;
  localparam logic [7:0] SLOT_CYC_FM  = 8'((SLOT_NS_FM * CLK_MHZ) / 1000);
  localparam logic [7:0] SLOT_CYC_MFM = 8'((SLOT_NS_MFM * CLK_MHZ) / 1000);
  localparam logic [7:0] PULSE_CYC    = 8'((PULSE_NS * CLK_MHZ) / 1000);

  //==============================================================
  // byte values and raw patterns
  localparam logic [7:0]  ID_MARK       = 8'hfe;
  localparam logic [7:0]  DATA_MARK     = 8'hfb;
  localparam logic [7:0]  FM_MARK_CLOCK = 8'hc7;
  localparam logic [7:0]  SYNC_BYTE     = 8'ha1;
  localparam logic [15:0] SYNC_CLR_MASK = 16'h0020;
  localparam logic [7:0]  MFM_GAP_BYTE  = 8'h4e;
  localparam logic [7:0]  ONES_BYTE     = 8'hff;
  localparam logic [7:0]  ZERO_BYTE     = 8'h00;
  localparam logic [15:0] ZERO_RAW      = 16'haaaa;

  //==============================================================
  // field and gap counts
  localparam logic [3:0]  PRE_BYTES_FM  = 4'h6;
  localparam logic [3:0]  PRE_BYTES_MFM = 4'hc;
  localparam logic [3:0]  ZERO_MIN_FM   = 4'h2;
  localparam logic [3:0]  ZERO_MIN_MFM  = 4'h4;
  localparam logic [1:0]  SYNC_COUNT    = 2'h3;
  localparam logic [10:0] ID_BYTES      = 11'h004;
  localparam logic [10:0] CRC_BYTES     = 11'h002;
  localparam logic [10:0] SKIP_BYTES    = 11'h008;
  localparam logic [3:0]  LAST_SLOT     = 4'hf;

  //==============================================================
  // modes
  typedef enum logic [1:0] {FILL_ONES, FILL_VARIANT, FILL_ZERO} fill_mode_t;
  typedef enum logic [1:0] {
    POST_INDEX_GAP, ID_TO_DATA_GAP, INTER_SECTOR_GAP, END_OF_TRACK_GAP
  } gap_kind_t;
  typedef enum logic [1:0] {WR_GAP_ONLY, WR_ID_FIELD, WR_DATA_FIELD} wr_kind_t;

endpackage

// ---- rtl/byte_fifo.sv ----
`timescale 1ns/1ps
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             sys_clk_in,   // clock
  input  wire logic             rst_n_in,     // async reset
  input  wire logic             in_valid_in,  // push request
  input  wire logic [WIDTH-1:0] in_data_in,   // push data
  output logic                  in_ready_out, // room left
  output logic                  out_valid_out,// entry present
  input  wire logic             out_ready_in, // pop request
  output logic [WIDTH-1:0]      out_data_out  // head entry
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0]                 wp;
    logic [AW:0]                 rp;
    logic                        rdy;
  } fifo_st_t;

  fifo_st_t st_q;
  fifo_st_t st_d;
  logic     push;
  logic     pop;

  //==============================================================
  // pointers carry one extra bit so full and empty differ
  assign out_valid_out = (st_q.wp != st_q.rp);
  assign out_data_out  = st_q.mem[st_q.rp[AW-1:0]];
  assign in_ready_out  = st_q.rdy;
  assign push          = in_valid_in & st_q.rdy;
  assign pop           = out_ready_in & out_valid_out;

  always_comb begin
    st_d = st_q;
    for (int i = 0; i < DEPTH; i++) begin
      if (push && (st_q.wp[AW-1:0] == AW'(i))) begin
        st_d.mem[i] = in_data_in;
      end
    end
    if (push) begin
      st_d.wp = st_q.wp + 1'b1;
    end
    if (pop) begin
      st_d.rp = st_q.rp + 1'b1;
    end
    st_d.rdy = ((st_d.wp - st_d.rp) != (AW+1)'(DEPTH));
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_q     <= '0;
      st_q.rdy <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end
endmodule

// ---- rtl/diskette_sync_address_mark.sv ----
`timescale 1ns/1ps
module diskette_sync_address_mark
  import dsk_sync_pkg::*;
(
  input  wire logic        sys_clk_in,       // 100 MHz clock
  input  wire logic        rst_n_in,         // async reset, active low
  input  wire logic        density_mfm_in,   // 1 = MFM, 0 = FM
  input  wire logic [1:0]  fill_mode_in,     // fill_mode_t
  input  wire logic        read_pulse_in,    // drive read pulse pin
  input  wire logic        rd_enable_in,     // sector search active
  input  wire logic [10:0] data_len_in,      // data field payload bytes
  input  wire logic        wr_start_in,      // start a write sequence
  input  wire logic [1:0]  wr_kind_in,       // wr_kind_t
  input  wire logic [1:0]  gap_kind_in,      // gap_kind_t of leading gap
  input  wire logic [7:0]  gap_len_in,       // leading gap bytes
  input  wire logic        wr_valid_in,      // payload byte offered
  input  wire logic [7:0]  wr_data_in,       // payload byte
  output logic             wr_ready_out,     // payload buffer has room
  output logic [7:0]       rd_byte_out,      // decoded byte
  output logic             rd_strobe_out,    // decoded byte valid pulse
  output logic             rd_mark_out,      // byte is a field_marker
  output logic             rd_crc_out,       // byte is a CRC byte
  output logic             rd_data_field_out,// byte belongs to data field
  output logic             rd_aligned_out,   // bit alignment held
  output logic             wr_pulse_out,     // write pulse to drive
  output logic             wr_gate_out,      // write current on
  output logic             wr_busy_out,      // write sequence running
  output logic             wr_underrun_out   // payload ran dry, sticky
);

  typedef enum logic [2:0] {R_HUNT, R_PRE, R_SYNC, R_MARK, R_FIELD, R_SKIP} rd_state_t;
  typedef enum logic [2:0] {W_IDLE, W_LEAD, W_GAP, W_PRE, W_SYNC, W_MARK, W_BODY, W_TAIL} wr_state_t;

  typedef struct packed {
    logic [1:0]  rsync;
    logic        rprev;
    logic [7:0]  rtmr;
    logic        rseen;
    logic [15:0] rsh;
    logic [3:0]  rslot;
    rd_state_t   rst;
    logic [3:0]  zcnt;
    logic [1:0]  a1cnt;
    logic        rdata;
    logic [10:0] rcnt;
    logic [7:0]  rbyte;
    logic        rstb;
    logic        rmark;
    logic        rcrc;
    logic        raligned;
    wr_state_t   wst;
    logic [7:0]  wtmr;
    logic [15:0] wsh;
    logic [3:0]  wslot;
    logic        wlast;
    logic [10:0] wcnt;
    logic [1:0]  wkind;
    logic [1:0]  wgkind;
    logic [7:0]  wglen;
    logic [10:0] wlen;
    logic        wpulse;
    logic        wgate;
    logic        wunder;
    logic        wbusy;
  } st_t;

  st_t        st_q;
  st_t        st_d;
  logic       fifo_valid;
  logic [7:0] fifo_data;
  logic       fifo_pop;

  //==============================================================
  // encoding helpers
  function automatic logic [15:0] interleave(input logic [7:0] clk, input logic [7:0] dat);
    logic [15:0] r;
    r = '0;
    for (int i = 0; i < 8; i++) begin
      r[2*i+1] = clk[i];
      r[2*i]   = dat[i];
    end
    return r;
  endfunction

  function automatic logic [15:0] encode(input logic [7:0] dat, input logic prev, input logic mfm);
    logic [7:0] clk;
    logic       p;
    clk = '0;
    p   = prev;
    for (int i = 7; i >= 0; i--) begin
      clk[i] = mfm ? (~p & ~dat[i]) : 1'b1;
      p      = dat[i];
    end
    return interleave(clk, dat);
  endfunction

  function automatic logic [7:0] decode(input logic [15:0] raw);
    logic [7:0] d;
    d = '0;
    for (int i = 0; i < 8; i++) begin
      d[i] = raw[2*i];
    end
    return d;
  endfunction

  //==============================================================
  // mark patterns per density
  logic [15:0] sync_raw;
  logic [15:0] fm_id_raw;
  logic [15:0] fm_data_raw;
  logic [15:0] mfm_id_raw;
  logic [15:0] mfm_data_raw;

  assign sync_raw     = encode(SYNC_BYTE, 1'b0, 1'b1) & ~SYNC_CLR_MASK;
  assign fm_id_raw    = interleave(FM_MARK_CLOCK, ID_MARK);
  assign fm_data_raw  = interleave(FM_MARK_CLOCK, DATA_MARK);
  assign mfm_id_raw   = encode(ID_MARK, SYNC_BYTE[0], 1'b1);
  assign mfm_data_raw = encode(DATA_MARK, SYNC_BYTE[0], 1'b1);

  //==============================================================
  // payload buffer between controller and serializer
  byte_fifo #(
    .WIDTH (8),
    .DEPTH (4)
  ) u_wr_fifo (
    .sys_clk_in    (sys_clk_in),
    .rst_n_in      (rst_n_in),
    .in_valid_in   (wr_valid_in),
    .in_data_in    (wr_data_in),
    .in_ready_out  (wr_ready_out),
    .out_valid_out (fifo_valid),
    .out_ready_in  (fifo_pop),
    .out_data_out  (fifo_data)
  );

  //==============================================================
  // next state
  logic [7:0]  slot_cyc;
  logic        redge;
  logic        rslot_end;
  logic [15:0] rnew;
  logic [7:0]  rdat;
  logic [3:0]  zmin;
  logic [10:0] flen;
  logic        wslot_end;
  logic        wbound;
  logic [7:0]  gap_fill;
  logic [7:0]  tail_fill;
  logic [7:0]  mark_val;
  logic [3:0]  pre_bytes;

  always_comb begin
    st_d      = st_q;
    fifo_pop  = 1'b0;
    slot_cyc  = density_mfm_in ? SLOT_CYC_MFM : SLOT_CYC_FM;
    zmin      = density_mfm_in ? ZERO_MIN_MFM : ZERO_MIN_FM;
    pre_bytes = density_mfm_in ? PRE_BYTES_MFM : PRE_BYTES_FM;
    redge     = st_q.rsync[1] & ~st_q.rprev;
    rslot_end = 1'b0;
    rnew      = {st_q.rsh[14:0], st_q.rseen};
    rdat      = decode(rnew);
    flen      = (st_q.rdata ? data_len_in : ID_BYTES) + CRC_BYTES;
    st_d.rstb = 1'b0;

    // ---- read pulse window, recentered on every pulse
    st_d.rsync = {st_q.rsync[0], read_pulse_in};
    st_d.rprev = st_q.rsync[1];
    if (redge) begin
      st_d.rseen = 1'b1;
      st_d.rtmr  = slot_cyc >> 1;
    end else if (st_q.rtmr >= slot_cyc - 8'h01) begin
      rslot_end  = 1'b1;
      st_d.rtmr  = '0;
      st_d.rseen = 1'b0;
      st_d.rsh   = rnew;
    end else begin
      st_d.rtmr = st_q.rtmr + 8'h01;
    end

    // ---- read byte framing
    if (!rd_enable_in) begin
      st_d.rst      = R_HUNT;
      st_d.raligned = 1'b0;
    end else if (rslot_end && (st_q.rst == R_HUNT)) begin
      if (rnew == ZERO_RAW) begin
        st_d.rst      = R_PRE;
        st_d.rslot    = '0;
        st_d.zcnt     = 4'h1;
        st_d.raligned = 1'b1;
      end
    end else if (rslot_end) begin
      st_d.rslot = st_q.rslot + 4'h1;
      if (st_q.rslot == LAST_SLOT) begin
        case (st_q.rst)
          R_PRE: begin
            if (rnew == ZERO_RAW) begin
              if (st_q.zcnt != LAST_SLOT) begin
                st_d.zcnt = st_q.zcnt + 4'h1;
              end
            end else if (st_q.zcnt < zmin) begin
              st_d.rst = R_HUNT;
            end else if (density_mfm_in && (rnew == sync_raw)) begin
              st_d.rst   = R_SYNC;
              st_d.a1cnt = 2'h1;
            end else if (!density_mfm_in && ((rnew == fm_id_raw) || (rnew == fm_data_raw))) begin
              st_d.rst   = R_FIELD;
              st_d.rdata = (rnew == fm_data_raw);
              st_d.rcnt  = '0;
              st_d.rbyte = rdat;
              st_d.rstb  = 1'b1;
              st_d.rmark = 1'b1;
              st_d.rcrc  = 1'b0;
            end else begin
              st_d.rst = R_HUNT;
            end
          end
          R_SYNC: begin
            if (rnew != sync_raw) begin
              st_d.rst = R_HUNT;
            end else if (st_q.a1cnt == SYNC_COUNT - 2'h1) begin
              st_d.rst = R_MARK;
            end else begin
              st_d.a1cnt = st_q.a1cnt + 2'h1;
            end
          end
          R_MARK: begin
            if ((rnew == mfm_id_raw) || (rnew == mfm_data_raw)) begin
              st_d.rst   = R_FIELD;
              st_d.rdata = (rnew == mfm_data_raw);
              st_d.rcnt  = '0;
              st_d.rbyte = rdat;
              st_d.rstb  = 1'b1;
              st_d.rmark = 1'b1;
              st_d.rcrc  = 1'b0;
            end else begin
              st_d.rst = R_HUNT;
            end
          end
          R_FIELD: begin
            st_d.rbyte = rdat;
            st_d.rstb  = 1'b1;
            st_d.rmark = 1'b0;
            st_d.rcrc  = (st_q.rcnt >= flen - CRC_BYTES);
            st_d.rcnt  = st_q.rcnt + 11'h001;
            if (st_q.rcnt == flen - 11'h001) begin
              st_d.rcnt = '0;
              st_d.rst  = st_q.rdata ? R_HUNT : R_SKIP;
            end
          end
          R_SKIP: begin
            // id_to_data_gap glitches cannot be read as a mark here
            st_d.rcnt = st_q.rcnt + 11'h001;
            if (st_q.rcnt == SKIP_BYTES - 11'h001) begin
              st_d.rst = R_HUNT;
            end
          end
          default: st_d.rst = R_HUNT;
        endcase
      end
    end
    if (st_d.rst == R_HUNT) begin
      st_d.raligned = 1'b0;
    end

    // ---- write fill values
    if (density_mfm_in) begin
      gap_fill  = MFM_GAP_BYTE;
      tail_fill = MFM_GAP_BYTE;
    end else if (fill_mode_in == FILL_ZERO) begin
      gap_fill  = ZERO_BYTE;
      tail_fill = ZERO_BYTE;
    end else if ((fill_mode_in == FILL_VARIANT) && (st_q.wgkind != ID_TO_DATA_GAP)) begin
      gap_fill  = ZERO_BYTE;
      tail_fill = ONES_BYTE;
    end else begin
      gap_fill  = ONES_BYTE;
      tail_fill = ONES_BYTE;
    end
    mark_val = (st_q.wkind == WR_DATA_FIELD) ? DATA_MARK : ID_MARK;

    // ---- write serializer slot timing
    wslot_end = 1'b0;
    if (st_q.wgate) begin
      if (st_q.wtmr >= slot_cyc - 8'h01) begin
        wslot_end  = 1'b1;
        st_d.wtmr  = '0;
        st_d.wsh   = {st_q.wsh[14:0], 1'b0};
        st_d.wslot = st_q.wslot + 4'h1;
      end else begin
        st_d.wtmr = st_q.wtmr + 8'h01;
      end
    end
    wbound = (wslot_end && (st_q.wslot == LAST_SLOT)) || (st_q.wst == W_LEAD);

    // ---- write sequencer, one step per byte boundary
    if ((st_q.wst == W_IDLE) && wr_start_in) begin
      st_d.wst    = W_LEAD;
      st_d.wkind  = wr_kind_in;
      st_d.wgkind = gap_kind_in;
      st_d.wglen  = gap_len_in;
      st_d.wlen   = data_len_in;
      st_d.wunder = 1'b0;
    end else if (wbound) begin
      st_d.wcnt = st_q.wcnt + 11'h001;
      case (st_q.wst)
        W_LEAD: begin
          st_d.wcnt = '0;
          if (st_q.wglen != 8'h00) begin
            st_d.wst = W_GAP;
          end else begin
            st_d.wst = (st_q.wkind == WR_GAP_ONLY) ? W_IDLE : W_PRE;
          end
        end
        W_GAP: begin
          if (st_q.wcnt == {3'h0, st_q.wglen} - 11'h001) begin
            st_d.wcnt = '0;
            st_d.wst  = (st_q.wkind == WR_GAP_ONLY) ? W_IDLE : W_PRE;
          end
        end
        W_PRE: begin
          if (st_q.wcnt == {7'h00, pre_bytes} - 11'h001) begin
            st_d.wcnt = '0;
            st_d.wst  = density_mfm_in ? W_SYNC : W_MARK;
          end
        end
        W_SYNC: begin
          if (st_q.wcnt == {9'h000, SYNC_COUNT} - 11'h001) begin
            st_d.wst = W_MARK;
          end
        end
        W_MARK: begin
          st_d.wcnt = '0;
          st_d.wst  = W_BODY;
        end
        W_BODY: begin
          if (st_q.wcnt == ((st_q.wkind == WR_DATA_FIELD) ? st_q.wlen : ID_BYTES) + CRC_BYTES - 11'h001) begin
            st_d.wst = W_TAIL;
          end
        end
        // tail keeps current on one full byte past the last CRC
        W_TAIL: st_d.wst = W_IDLE;
        default: st_d.wst = W_IDLE;
      endcase

      st_d.wslot = '0;
      st_d.wtmr  = '0;
      case (st_d.wst)
        W_GAP: st_d.wsh = encode(gap_fill, st_q.wlast, density_mfm_in);
        W_PRE: st_d.wsh = encode(ZERO_BYTE, st_q.wlast, density_mfm_in);
        W_SYNC: st_d.wsh = sync_raw;
        W_MARK: begin
          st_d.wsh = density_mfm_in ? encode(mark_val, SYNC_BYTE[0], 1'b1)
                                    : interleave(FM_MARK_CLOCK, mark_val);
        end
        W_BODY: begin
          // controller supplies payload and CRC; a dry buffer writes zeros
          fifo_pop = fifo_valid;
          st_d.wsh = encode(fifo_valid ? fifo_data : ZERO_BYTE, st_q.wlast, density_mfm_in);
          if (!fifo_valid) begin
            st_d.wunder = 1'b1;
          end
        end
        W_TAIL: st_d.wsh = encode(tail_fill, st_q.wlast, density_mfm_in);
        default: st_d.wsh = '0;
      endcase
      st_d.wlast = st_d.wsh[0];
    end

    st_d.wgate  = (st_d.wst != W_IDLE) && (st_d.wst != W_LEAD);
    st_d.wbusy  = (st_d.wst != W_IDLE);
    st_d.wpulse = st_d.wgate && st_d.wsh[15] && (st_d.wtmr < PULSE_CYC);
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_q     <= '0;
      st_q.rst <= R_HUNT;
      st_q.wst <= W_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  //==============================================================
  // outputs
  assign rd_byte_out       = st_q.rbyte;
  assign rd_strobe_out     = st_q.rstb;
  assign rd_mark_out       = st_q.rmark;
  assign rd_crc_out        = st_q.rcrc;
  assign rd_data_field_out = st_q.rdata;
  assign rd_aligned_out    = st_q.raligned;
  assign wr_pulse_out      = st_q.wpulse;
  assign wr_gate_out       = st_q.wgate;
  assign wr_busy_out       = st_q.wbusy;
  assign wr_underrun_out   = st_q.wunder;
endmodule

// ---- dv/dsk_sync_checker_assertions.sv ----
`timescale 1ns/1ps
module dsk_sync_checker
  import dsk_sync_pkg::*;
(
  input wire logic       sys_clk_in,     // clock
  input wire logic       rst_n_in,       // reset
  input wire logic       rd_enable_in,   // search on
  input wire logic       wr_start_in,    // start
  input wire logic [1:0] wr_kind_in,     // write kind
  input wire logic [7:0] gap_len_in,     // gap bytes
  input wire logic [7:0] rd_byte_out,    // byte
  input wire logic       rd_strobe_out,  // strobe
  input wire logic       rd_mark_out,    // mark flag
  input wire logic       rd_crc_out,     // crc flag
  input wire logic       rd_aligned_out, // aligned
  input wire logic       wr_pulse_out,   // write pulse
  input wire logic       wr_gate_out,    // write gate
  input wire logic       wr_busy_out     // busy
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  //==============================================================
  // write launch
  sequence s_take;
    wr_start_in && !wr_busy_out && (wr_kind_in != 2'h0 || gap_len_in != 8'h00);
  endsequence
  sequence s_launch;
    wr_busy_out && !wr_gate_out ##1 wr_busy_out && wr_gate_out;
  endsequence
  AST_WR_LAUNCH: assert property (s_take |=> s_launch) else $error("write gate launch late");
  AST_GATE_END: assert property ($fell(wr_gate_out) |-> $fell(wr_busy_out)) else $error("gate off early");
  AST_GATE_IN_BUSY: assert property (wr_gate_out |-> wr_busy_out) else $error("gate without busy");
  //==============================================================
  // pulse shape
  AST_PULSE_GATED: assert property (wr_pulse_out |-> wr_gate_out) else $error("pulse without gate");
  AST_PULSE_WIDTH: assert property ($rose(wr_pulse_out) |-> (wr_pulse_out throughout ##24 1) ##1 !wr_pulse_out)
    else $error("pulse width wrong");
  AST_PULSE_GAP: assert property ($fell(wr_pulse_out) |-> (!wr_pulse_out throughout ##74 1))
    else $error("pulses too close");
  //==============================================================
  // read side
  AST_STROBE_ONE: assert property (rd_strobe_out |=> !rd_strobe_out) else $error("strobe too long");
  AST_MARK_OK: assert property (rd_strobe_out && rd_mark_out |-> rd_aligned_out && !rd_crc_out &&
    (rd_byte_out == ID_MARK || rd_byte_out == DATA_MARK)) else $error("bad mark");
  AST_HUNT: assert property (!rd_enable_in ##1 !rd_enable_in |-> !rd_aligned_out && !rd_strobe_out)
    else $error("alignment kept while off");
endmodule
bind diskette_sync_address_mark dsk_sync_checker u_chk (.sys_clk_in, .rst_n_in, .rd_enable_in, .wr_start_in,
  .wr_kind_in, .gap_len_in, .rd_byte_out, .rd_strobe_out, .rd_mark_out, .rd_crc_out, .rd_aligned_out,
  .wr_pulse_out, .wr_gate_out, .wr_busy_out);

// ---- dv/drive_model.sv ----
`timescale 1ns/1ps
module drive_model
  import dsk_sync_pkg::*;
(
  input  wire logic sys_clk_in,     // clock
  input  wire logic density_mfm_in, // 1 = MFM
  input  wire logic wr_pulse_in,    // write pulse
  input  wire logic wr_gate_in,     // write current
  output logic      read_pulse_out  // read pulse
);
  logic       trk[$];
  int         n = 0;
  logic [7:0] slot;
  assign slot = density_mfm_in ? SLOT_CYC_MFM : SLOT_CYC_FM;
  initial read_pulse_out = 1'b0;
  //==============================================================
  // record one bit per slot, fresh track at each gate-on
  always @(posedge sys_clk_in) begin
    if (!wr_gate_in) n = 0;
    else begin
      if (n == 0) trk.delete();
      if (n % int'(slot) == 0) trk.push_back(wr_pulse_in);
      n++;
    end
  end
  //==============================================================
  // playback, line quiet between frames
  task automatic play(input logic [15:0] w[$]);
    foreach (w[i]) for (int b = 15; b >= 0; b--) begin
      read_pulse_out = w[i][b];
      repeat (PULSE_CYC) @(negedge sys_clk_in);
      read_pulse_out = 1'b0;
      repeat (slot - PULSE_CYC) @(negedge sys_clk_in);
    end
  endtask
endmodule

// ---- dv/tb_diskette_sync_address_mark.sv ----
`timescale 1ns/1ps
module tb_diskette_sync_address_mark;
  import dsk_sync_pkg::*;
  typedef struct {logic mfm; logic [1:0] fill, kind, gk; logic [7:0] glen, fb;} row_t;
  logic sys_clk_in = 1'b0, rst_n_in, density_mfm_in, rd_enable_in, wr_start_in, read_pulse_in;
  logic [1:0] fill_mode_in, wr_kind_in, gap_kind_in;
  logic [10:0] data_len_in;
  logic [7:0] gap_len_in, rd_byte_out, wr_data_in = 8'h00;
  logic wr_valid_in = 1'b0, wr_ready_out, rd_strobe_out, rd_mark_out, rd_crc_out, rd_data_field_out;
  logic rd_aligned_out, wr_pulse_out, wr_gate_out, wr_busy_out, wr_underrun_out, m, pb;
  logic [7:0] fq[$];
  logic [15:0] ew[$];
  logic [10:0] rq[$];
  int num_errors = 0, n_tests = 0;
  row_t rows[5] = '{
    '{1'b0, 2'h0, 2'h0, 2'h1, 8'h01, 8'hff},
    '{1'b0, 2'h1, 2'h0, 2'h0, 8'h01, 8'h00},
    '{1'b0, 2'h1, 2'h0, 2'h1, 8'h01, 8'hff},
    '{1'b0, 2'h2, 2'h0, 2'h1, 8'h01, 8'h00},
    '{1'b1, 2'h0, 2'h2, 2'h3, 8'h01, 8'h4e}};

  diskette_sync_address_mark DUT (.sys_clk_in, .rst_n_in, .density_mfm_in, .fill_mode_in, .read_pulse_in,
    .rd_enable_in, .data_len_in, .wr_start_in, .wr_kind_in, .gap_kind_in, .gap_len_in, .wr_valid_in,
    .wr_data_in, .wr_ready_out, .rd_byte_out, .rd_strobe_out, .rd_mark_out, .rd_crc_out, .rd_data_field_out,
    .rd_aligned_out, .wr_pulse_out, .wr_gate_out, .wr_busy_out, .wr_underrun_out);
  drive_model u_drive (.sys_clk_in, .density_mfm_in, .wr_pulse_in(wr_pulse_out), .wr_gate_in(wr_gate_out),
    .read_pulse_out(read_pulse_in));

  always #5 sys_clk_in = ~sys_clk_in;
  always @(posedge sys_clk_in) if (wr_valid_in && wr_ready_out === 1'b1) void'(fq.pop_front());
  always @(negedge sys_clk_in) begin
    wr_valid_in <= fq.size() > 0;
    wr_data_in  <= fq.size() > 0 ? fq[0] : 8'h00;
  end
  always @(posedge sys_clk_in) if (rd_strobe_out === 1'b1)
    rq.push_back({rd_mark_out, rd_crc_out, rd_data_field_out, rd_byte_out});

  //==============================================================
  // checking and ending
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    if (num_errors == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (150000) @(posedge sys_clk_in);
    num_errors++;
    stop_test();
  end

  //==============================================================
  // expected raw stream, clock bit before data bit
  function automatic logic [15:0] enc(input logic [7:0] d, input logic [7:0] c);
    logic [15:0] w;
    for (int i = 7; i >= 0; i--) begin
      w[2*i+1] = m ? (!pb && !d[i]) : c[i];
      w[2*i]   = d[i];
      pb       = d[i];
    end
    return w;
  endfunction
  task automatic put(input logic [7:0] d, input int k = 1, input logic [7:0] c = ONES_BYTE);
    repeat (k) ew.push_back(enc(d, c));
  endtask
  task automatic sync(input int k);
    repeat (k) ew.push_back(enc(SYNC_BYTE, ONES_BYTE) & ~SYNC_CLR_MASK);
  endtask
  task automatic fresh(input logic mm);
    m = mm;
    pb = 1'b0;
    ew.delete();
    density_mfm_in = mm;
  endtask

  //==============================================================
  // one write sequence against the recorded track
  task automatic do_write(input row_t r);
    logic [15:0] w;
    int t;
    fresh(r.mfm);
    fill_mode_in = r.fill;
    wr_kind_in = r.kind;
    gap_kind_in = r.gk;
    gap_len_in = r.glen;
    put(r.fb, r.glen);
    if (r.kind != WR_GAP_ONLY) begin
      fq = '{ID_MARK, SYNC_BYTE, MFM_GAP_BYTE, ONES_BYTE};
      data_len_in = 11'h002;
      put(ZERO_BYTE, r.mfm ? PRE_BYTES_MFM : PRE_BYTES_FM);
      if (r.mfm) sync(3);
      put(DATA_MARK, 1, FM_MARK_CLOCK);
      foreach (fq[i]) put(fq[i]);
      put(r.fb);
      repeat (8) @(negedge sys_clk_in);
      chk(wr_ready_out, 1'b0);
    end
    wr_start_in = 1'b1;
    @(negedge sys_clk_in);
    wr_start_in = 1'b0;
    repeat (3) @(negedge sys_clk_in);
    wr_start_in = 1'b1; // ignored while busy
    @(negedge sys_clk_in);
    wr_start_in = 1'b0;
    t = 0;
    while (wr_busy_out === 1'b1 && t < 80000) begin
      @(negedge sys_clk_in);
      t++;
    end
    chk({wr_gate_out, wr_underrun_out, wr_ready_out}, 3'h1);
    chk(u_drive.trk.size(), 32'(ew.size() * 16));
    foreach (ew[i]) begin
      for (int b = 0; b < 16; b++) w[15-b] = u_drive.trk[i*16+b];
      chk(w, ew[i]);
    end
  endtask

  task automatic do_read(input logic [10:0] exp[$]);
    rq.delete();
    rd_enable_in = 1'b1;
    u_drive.play(ew);
    repeat (400) @(negedge sys_clk_in);
    chk(rq.size(), exp.size());
    foreach (exp[i]) chk(rq[i], exp[i]);
    rd_enable_in = 1'b0;
    repeat (4) @(negedge sys_clk_in);
  endtask

  //==============================================================
  // main sequence
  initial begin
    rst_n_in = 1'b0;
    {density_mfm_in, fill_mode_in, rd_enable_in, wr_start_in, wr_kind_in, gap_kind_in} = '0;
    data_len_in = 11'h000;
    gap_len_in = 8'h00;
    repeat (16) @(negedge sys_clk_in);
    chk({wr_ready_out, wr_gate_out, wr_busy_out, rd_strobe_out, rd_aligned_out, wr_pulse_out}, 6'h20);
    rst_n_in = 1'b1;
    foreach (rows[i]) do_write(rows[i]);
    // replay the last track from its tenth word; four zero bytes still lead the mark
    ew.delete();
    for (int i = 9; i < u_drive.trk.size() / 16; i++)
      for (int b = 0; b < 16; b++) begin
        if (b == 0) ew.push_back(16'h0000);
        ew[$][15-b] = u_drive.trk[i*16+b];
      end
    do_read('{11'h5fb, 11'h1fe, 11'h1a1, 11'h34e, 11'h3ff});
    fresh(1'b0);
    data_len_in = 11'h001;
    put(ZERO_BYTE, 2);
    put(DATA_MARK, 1, FM_MARK_CLOCK);
    put(8'h5a);
    put(8'h12);
    put(8'h34);
    do_read('{11'h5fb, 11'h15a, 11'h312, 11'h334});
    fresh(1'b0);
    put(ZERO_BYTE, 2);
    put(ID_MARK);
    do_read('{});
    fresh(1'b1);
    put(ZERO_BYTE, 4);
    sync(2);
    put(ID_MARK);
    do_read('{});
    fresh(1'b1);
    put(MFM_GAP_BYTE, 1);
    sync(3);
    put(ID_MARK);
    do_read('{});
    stop_test();
  end
endmodule
